// [design/err_word_cfg.svh]
/*
 * timing-free constants for the error code word logic: error number
 * ranges, forced-error numbers and reset values.
 * assumes inclusion by bare name from the design files.
 */
`ifndef ERR_WORD_CFG_SVH
`define ERR_WORD_CFG_SVH

`define PRESCAN_ERR_MIN 7'd1
`define PRESCAN_ERR_MAX 7'd29
`define FORMAT_ERR_MIN 7'd30
`define FORMAT_ERR_MAX 7'd39
`define REPLY_ERR_MIN 7'd50
`define REPLY_ERR_MAX 7'd59
`define REMOTE_ERR_MIN 7'd80
`define REMOTE_ERR_MAX 7'd89
`define LOCAL_ERR_MIN 7'd90
`define LOCAL_ERR_MAX 7'd99
`define FORCE_ERR_A 7'd32
`define FORCE_ERR_B 7'd33
`define FORCE_ERR_C 7'd34
`define FORCE_ERR_D 7'd54
`define ERR_WORD_RESET 16'h0000
`define DIAG_CNT_RESET 8'h00
`define BCD_LAST 4'h9

`endif

// [design/err_word_pkg.sv]
/*
 * types shared by the error code word logic.
 * assumes the cfg header is available by bare name.
 */
package err_word_pkg;

    // one error report from the module's own logic
    typedef struct packed {
        logic valid;
        logic [6:0] number;
    } err_event_t;

    // reply arriving from a peer station
    typedef struct packed {
        logic valid;
        logic [7:0] reply_status_byte;
        logic [7:0] extended_reply_status_byte;
    } reply_in_t;

    // four bcd digits, high pair and low pair
    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] number;
    } err_word_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_FAULT = 3'b100
    } mode_state_t;

endpackage

// [design/bcd_pair_counter.sv]
/*
 * two-digit bcd counter, wrapping 99 to 00.
 * assumes a synchronous clear and a one-cycle step pulse.
 */
`timescale 1ns/1ps
`include "err_word_cfg.svh"

module bcd_pair_counter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clear,
    input wire logic load_one,
    input wire logic step,
    output logic [7:0] value
);
    logic [7:0] value_reg;
    logic [7:0] value_next;
    logic [3:0] lo_inc;
    logic [3:0] hi_inc;

    // digit arithmetic, low digit carries into high
    assign lo_inc = (value_reg[3:0] == `BCD_LAST) ? 4'h0 :
                    value_reg[3:0] + 4'h1;
    assign hi_inc = (value_reg[7:4] == `BCD_LAST) ? 4'h0 :
                    value_reg[7:4] + 4'h1;
    assign value_next = clear ? 8'h00 :
                        load_one ? 8'h01 :
                        !step ? value_reg :
                        (value_reg[3:0] == `BCD_LAST) ? {hi_inc, 4'h0} :
                        {value_reg[7:4], lo_inc};
    assign value = value_reg;

    // counter state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= 8'h00;
        end else if (ce) begin
            value_reg <= value_next;
        end
    end
endmodule

// [design/err_code_word.sv]
/*
 * error code word of a network interface module: four bcd digits,
 * error number low, rung pointer or run-time count high.
 * assumes event inputs come from logic on core_clk; the program mode
 * switch is a pin and is synchronised here.
 */
// Summary of operation
// - error word is four bcd digits
// - low two digits are error number; upper meaning depends on group
// - prescan syntax errors use numbers 1 to 29
// - prescan error lights indicator, enters error state; program mode exits
// - prescan upper digits point to failing rung, 1..99 then 0..99
// - first rung after the header rung is number one
// - clean prescan end clears the whole word
// - header rung unchecked; search continues until valid header or end
// - run-time upper digits count errors modulo 100, first is one
// - run-time errors continue operation except forcing numbers
// - formatting errors 30 to 39, some force error state
// - reply errors 50 to 59
// - remote status byte 80 to 89 copied into word
// - local transmit failures 90 to 99
// - internal error counters held as ram bytes, diagnostic read only
// - replies keep being generated while functioning, even with status
`timescale 1ns/1ps
`include "err_word_cfg.svh"

module err_code_word #(
    parameter int DIAG_COUNTERS = 8,
    parameter int DIAG_AW = 3
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic program_switch,
    input wire logic prescan_start,
    input wire logic header_candidate,
    input wire logic header_valid,
    input wire logic end_of_memory,
    input wire logic rung_done,
    input wire logic prescan_done,
    input wire err_word_pkg::err_event_t err_in,
    input wire err_word_pkg::reply_in_t reply_in,
    input wire logic diag_rd,
    input wire logic [DIAG_AW-1:0] diag_addr,
    output err_word_pkg::err_word_t err_word,
    output logic program_mode_indicator,
    output logic error_state,
    output logic header_found,
    output logic reply_send,
    output logic [7:0] reply_status_out,
    output logic diag_valid,
    output logic [7:0] diag_data
);
    import err_word_pkg::*;

    logic rst_meta_reg, rst_sync_reg;
    logic program_mode_indicator_meta_reg, program_mode_indicator_sync_reg;
    mode_state_t state_reg, state_next;
    err_word_t word_reg, word_next;
    logic searching_reg, in_zone_reg;
    logic header_found_reg, reply_send_reg;
    logic [7:0] reply_status_reg;
    logic diag_valid_reg;
    logic [7:0] diag_data_reg;
    logic [7:0] diag_ram [DIAG_COUNTERS];
    logic [7:0] rung_cnt, err_cnt;
    logic remote_err, any_err, is_prescan, force_fault;
    logic is_format, is_reply, is_local;
    logic [6:0] err_num;
    logic [DIAG_AW-1:0] diag_sel;

    function automatic logic in_range(input logic [6:0] n,
                                      input logic [6:0] lo,
                                      input logic [6:0] hi);
        in_range = (n >= lo) && (n <= hi);
    endfunction

    // bcd successor of a count, 99 wraps to 00
    function automatic logic [7:0] bcd_succ(input logic [7:0] v);
        if (v[3:0] != `BCD_LAST) begin
            bcd_succ = {v[7:4], 4'(v[3:0] + 4'h1)};
        end else if (v[7:4] != `BCD_LAST) begin
            bcd_succ = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            bcd_succ = 8'h00;
        end
    endfunction

    // binary number to two bcd digits
    function automatic logic [7:0] to_bcd(input logic [6:0] n);
        logic [6:0] tens;
        tens = n / 7'd10;
        to_bcd = {tens[3:0], 4'(n - tens * 7'd10)};
    endfunction

    // reset assertion acts at once; only its release is retimed
    // reset release through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // program switch is a pin, synchronise before use
    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            program_mode_indicator_meta_reg <= 1'b0;
            program_mode_indicator_sync_reg <= 1'b0;
        end else if (clk_en) begin
            program_mode_indicator_meta_reg <= program_switch;
            program_mode_indicator_sync_reg <= program_mode_indicator_meta_reg;
        end
    end

    // remote status copy
    // bit 7 must be clear as well, so d5 hex is not taken for 85
    assign remote_err = reply_in.valid && !reply_in.reply_status_byte[7] &&
        in_range(reply_in.reply_status_byte[6:0], `REMOTE_ERR_MIN,
                 `REMOTE_ERR_MAX);
    // remote status wins when both arrive in one cycle
    assign err_num = remote_err ? reply_in.reply_status_byte[6:0] :
                     err_in.number;
    assign is_prescan = in_range(err_num, `PRESCAN_ERR_MIN,
                                 `PRESCAN_ERR_MAX);
    assign is_format = in_range(err_num, `FORMAT_ERR_MIN, `FORMAT_ERR_MAX);
    assign is_reply = in_range(err_num, `REPLY_ERR_MIN, `REPLY_ERR_MAX);
    assign is_local = in_range(err_num, `LOCAL_ERR_MIN, `LOCAL_ERR_MAX);
    // numbers outside every group leave the word alone
    assign any_err = remote_err || (err_in.valid &&
        (is_prescan || is_format || is_reply || is_local));
    // numbers that force the error state
    assign force_fault = any_err && (is_prescan ||
        err_num == `FORCE_ERR_A || err_num == `FORCE_ERR_B ||
        err_num == `FORCE_ERR_C || err_num == `FORCE_ERR_D);

    bcd_pair_counter rung_counter (
        .clk(core_clk),
        .rst_n(rst_sync_reg),
        .ce(clk_en),
        .clear(1'b0),
        .load_one(header_candidate && header_valid && searching_reg),
        .step(rung_done && in_zone_reg),
        .value(rung_cnt)
    );

    bcd_pair_counter error_counter (
        .clk(core_clk),
        .rst_n(rst_sync_reg),
        .ce(clk_en),
        .clear(prescan_start),
        .load_one(1'b0),
        .step(any_err && !is_prescan),
        .value(err_cnt)
    );

    // new error overwrites number and upper digits
    always_comb begin
        word_next = word_reg;
        if (any_err) begin
            word_next.number = to_bcd(err_num);
            // counter value still old here, so show its successor
            word_next.upper = is_prescan ? rung_cnt : bcd_succ(err_cnt);
        end else if (prescan_done && state_reg != ST_FAULT) begin
            word_next = `ERR_WORD_RESET;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (force_fault) begin
                    state_next = ST_FAULT;
                end else if (prescan_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (force_fault) begin
                    state_next = ST_FAULT;
                end
            end
            ST_FAULT: begin
                // a forcing error in the same cycle wins over the exit
                if (program_mode_indicator_sync_reg && !force_fault) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // main state and word
    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= ST_IDLE;
            word_reg <= `ERR_WORD_RESET;
        end else if (clk_en) begin
            state_reg <= state_next;
            word_reg <= word_next;
        end
    end

    // end of memory gives up the search, so a late header is ignored
    // header search without syntax check
    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            searching_reg <= 1'b0;
            in_zone_reg <= 1'b0;
            header_found_reg <= 1'b0;
        end else if (clk_en) begin
            if (prescan_start) begin
                searching_reg <= 1'b1;
                in_zone_reg <= 1'b0;
                header_found_reg <= 1'b0;
            end else if (searching_reg && header_candidate &&
                         header_valid) begin
                searching_reg <= 1'b0;
                in_zone_reg <= 1'b1;
                header_found_reg <= 1'b1;
            end else if (searching_reg && end_of_memory) begin
                searching_reg <= 1'b0;
            end else if (prescan_done) begin
                in_zone_reg <= 1'b0;
            end
        end
    end

    // status byte is held after the pulse for a slow reader
    // reply carries status whenever a message arrives
    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            reply_send_reg <= 1'b0;
            reply_status_reg <= 8'h00;
        end else if (clk_en) begin
            reply_send_reg <= reply_in.valid;
            if (reply_in.valid) begin
                reply_status_reg <= reply_in.reply_status_byte;
            end
        end
    end

    // counters indexed by the low three bits of the error number, read only via diagnostic port
    assign diag_sel = DIAG_AW'(err_num[2:0]);
    // counters are zeroed while reset is held, so reads never see unknowns
    always_ff @(posedge core_clk) begin
        if (!rst_sync_reg) begin
            for (int i = 0; i < DIAG_COUNTERS; i++) begin
                diag_ram[i] <= `DIAG_CNT_RESET;
            end
        end else if (clk_en && any_err) begin
            diag_ram[diag_sel] <= diag_ram[diag_sel] + 8'h01;
        end
    end

    // diagnostic read answer, one cycle later
    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            diag_valid_reg <= 1'b0;
            diag_data_reg <= `DIAG_CNT_RESET;
        end else if (clk_en) begin
            diag_valid_reg <= diag_rd;
            if (diag_rd) begin
                diag_data_reg <= diag_ram[diag_addr];
            end
        end
    end

    // error state and indicator share one flop, so they never disagree
    // outputs straight from flops
    assign err_word = word_reg;
    assign error_state = state_reg[2];
    assign program_mode_indicator = state_reg[2];
    assign header_found = header_found_reg;
    assign reply_send = reply_send_reg;
    assign reply_status_out = reply_status_reg;
    assign diag_valid = diag_valid_reg;
    assign diag_data = diag_data_reg;
endmodule

// [verification/err_code_word_asserts.sv]
/* port checks for the error code word block.
   assumes a bind onto err_code_word and the cfg header on the path. */
`timescale 1ns/1ps
`include "err_word_cfg.svh"
module err_code_word_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic program_switch,
    input wire logic header_candidate,
    input wire logic header_valid,
    input wire logic rung_done,
    input wire logic prescan_done,
    input wire logic diag_rd,
    input wire err_word_pkg::err_event_t err_in,
    input wire err_word_pkg::reply_in_t reply_in,
    input wire err_word_pkg::err_word_t err_word,
    input wire logic program_mode_indicator,
    input wire logic error_state,
    input wire logic diag_valid,
    input wire logic reply_send,
    input wire logic [7:0] reply_status_out
);
    import err_word_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    function automatic logic [7:0] bcd(input logic [7:0] n);
        return 8'((n / 10) * 16 + n % 10);
    endfunction
    function automatic logic [7:0] inc(input logic [7:0] u);
        return bcd(8'((u[7:4] * 10 + u[3:0] + 1) % 100));
    endfunction
    logic [6:0] num;
    logic ev, pre, rt, frc;
    // event decode; faults and same-cycle replies are left out on purpose
    assign num = err_in.number;
    assign ev = clk_en && err_in.valid && !reply_in.valid && !error_state;
    assign pre = ev && num inside {[`PRESCAN_ERR_MIN:`PRESCAN_ERR_MAX]};
    assign rt = ev && num inside {[`FORMAT_ERR_MIN:`FORMAT_ERR_MAX],
        [`REPLY_ERR_MIN:`REPLY_ERR_MAX], [`LOCAL_ERR_MIN:`LOCAL_ERR_MAX]};
    assign frc = num inside {`FORCE_ERR_A, `FORCE_ERR_B, `FORCE_ERR_C,
        `FORCE_ERR_D};
    sequence hdr_s;
        clk_en && header_candidate && header_valid;
    endsequence
    sequence rt_pair_s;
        rt ##1 rt;
    endsequence
    bcd_digits_a: assert property (
        err_word.upper[7:4] <= `BCD_LAST && err_word.upper[3:0] <= `BCD_LAST
        && err_word.number[7:4] <= `BCD_LAST
        && err_word.number[3:0] <= `BCD_LAST)
        else $error("error word digit above nine");
    prescan_err_a: assert property (pre |=> error_state &&
        program_mode_indicator && err_word.number == bcd({1'b0, $past(num)}))
        else $error("prescan error not recorded");
    rung_ptr_a: assert property (
        hdr_s ##1 !rung_done ##1 (pre && !rung_done) |=> err_word.upper == 8'h01)
        else $error("first rung pointer not one");
    hold_fault_a: assert property (
        error_state && !$past(program_switch, 2) |=> error_state)
        else $error("error state left without program mode");
    program_mode_indicator_exit_a: assert property (
        (clk_en && program_switch && !err_in.valid) [*4] |=>
        !error_state && !program_mode_indicator)
        else $error("program mode did not clear error state");
    clean_clear_a: assert property (clk_en && prescan_done &&
        !error_state && !err_in.valid && !reply_in.valid |=> err_word == '0)
        else $error("clean prescan left error word set");
    run_count_a: assert property (
        rt_pair_s |=> err_word.upper == inc($past(err_word.upper)))
        else $error("run error count not stepped by one");
    force_sel_a: assert property (
        rt |=> error_state == $past(frc))
        else $error("run error state selection wrong");
    remote_copy_a: assert property (
        clk_en && reply_in.valid && !error_state && reply_in.reply_status_byte
        inside {[`REMOTE_ERR_MIN:`REMOTE_ERR_MAX]} |=>
        err_word.number == bcd($past(reply_in.reply_status_byte)))
        else $error("remote status not copied");
    refuse_a: assert property (ev && !prescan_done &&
        (num == 7'd0 || num inside {[40:49], [60:79]}) |=> $stable(err_word))
        else $error("refused number changed error word");
    diag_resp_a: assert property (clk_en && diag_rd |=> diag_valid)
        else $error("diagnostic read not answered");
    reply_echo_a: assert property (clk_en && reply_in.valid |=>
        reply_send && reply_status_out == $past(reply_in.reply_status_byte))
        else $error("reply not generated for arriving message");
endmodule

// [verification/peer_station.sv]
/* behavioural peer station that answers with a reply after a delay.
   assumes send is a one-cycle pulse on core_clk. */
`timescale 1ns/1ps
module peer_station (
    input wire logic core_clk,
    input wire logic send,
    input wire logic [7:0] status,
    input wire logic [3:0] delay,
    output err_word_pkg::reply_in_t reply_in
);
    import err_word_pkg::*;
    logic [3:0] cnt_reg = 4'h0;
    logic busy_reg = 1'b0;
    logic [7:0] last_reg = 8'h00;
    initial reply_in = '0;
    // idle status bytes flip each cycle so a stale value never looks real
    always @(posedge core_clk) begin
        reply_in.valid <= 1'b0;
        reply_in.reply_status_byte <= ~reply_in.reply_status_byte;
        if (send) begin
            busy_reg <= 1'b1;
            cnt_reg <= delay;
            last_reg <= status;
        end else if (busy_reg && cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end else if (busy_reg) begin
            busy_reg <= 1'b0;
            reply_in <= '{1'b1, last_reg, 8'h00};
        end
    end
endmodule

// [verification/tb_top.sv]
/* self-checking bench for the error code word block.
   assumes the checker and peer model are compiled first. */
`timescale 1ns/1ps
module tb_top;
    import err_word_pkg::*;
    logic core_clk, rst_n, clk_en, program_switch, prescan_start;
    logic header_candidate, header_valid, end_of_memory, rung_done;
    logic prescan_done, diag_rd, send, program_mode_indicator, error_state;
    logic header_found, reply_send, diag_valid;
    logic [2:0] diag_addr;
    logic [3:0] delay;
    logic [7:0] status, reply_status_out, diag_data;
    err_event_t err_in;
    reply_in_t reply_in;
    err_word_t err_word;
    int errors, n_compared;
    err_code_word #(.DIAG_COUNTERS(8), .DIAG_AW(3)) u_dut (.*);
    peer_station u_peer (.*);
    // free-running clock, 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] bcd(input int n);
        return 8'((n / 10) * 16 + n % 10);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // one error number held valid for reps edges
    task automatic ev(input logic [6:0] n, input int reps = 1);
        @(posedge core_clk) err_in <= '{1'b1, n};
        repeat (reps - 1) @(posedge core_clk);
        @(posedge core_clk) err_in <= '{1'b0, n};
        #1;
    endtask
    task automatic to_program;
        @(posedge core_clk) program_switch <= 1'b1;
        cyc(3);
        chk({error_state, program_mode_indicator}, 2'b00);
        @(posedge core_clk) program_switch <= 1'b0;
        cyc(4);
    endtask
    task automatic t_prescan(input int rungs, input logic [6:0] n);
        @(posedge core_clk) prescan_start <= 1'b1;
        @(posedge core_clk) {prescan_start, header_candidate} <= 2'b01;
        @(posedge core_clk) header_candidate <= 1'b0;
        #1 chk(header_found, 1'b0);
        @(posedge core_clk) {header_candidate, header_valid} <= 2'b11;
        @(posedge core_clk) {header_candidate, header_valid} <= 2'b00;
        #1 chk(header_found, 1'b1);
        if (rungs > 0) begin
            @(posedge core_clk) rung_done <= 1'b1;
            repeat (rungs - 1) @(posedge core_clk);
            @(posedge core_clk) rung_done <= 1'b0;
        end
        ev(n);
        chk(err_word, {bcd((rungs + 1) % 100), bcd(n)});
        chk({error_state, program_mode_indicator}, 2'b11);
        to_program;
        $display("prescan test finished");
    endtask
    task automatic t_clean;
        ev(7'd90);
        // a search given up at end of memory ignores a later header
        @(posedge core_clk) prescan_start <= 1'b1;
        @(posedge core_clk) {prescan_start, end_of_memory} <= 2'b01;
        @(posedge core_clk) {end_of_memory, header_candidate,
            header_valid} <= 3'b011;
        @(posedge core_clk) {header_candidate, header_valid} <= 2'b00;
        #1 chk(header_found, 1'b0);
        @(posedge core_clk) prescan_start <= 1'b1;
        @(posedge core_clk) {prescan_start, header_candidate,
            header_valid} <= 3'b011;
        @(posedge core_clk) {header_candidate, header_valid,
            prescan_done} <= 3'b001;
        @(posedge core_clk) prescan_done <= 1'b0;
        #1 chk(err_word, 16'h0000);
        $display("clean prescan test finished");
    endtask
    // count wraps past 100 errors; refusals leave the word alone
    task automatic t_runtime;
        for (int i = 1; i <= 101; i++) begin
            ev(7'(90 + i % 10));
            chk(err_word, {bcd(i % 100), bcd(90 + i % 10)});
        end
        ev(7'd51, 2);
        chk(err_word, 16'h0351);
        ev(7'd45);
        chk(err_word, 16'h0351);
        ev(7'd0);
        chk(err_word, 16'h0351);
        ev(7'd36);
        chk({err_word, error_state}, {16'h0436, 1'b0});
        // clock enable low freezes the word against a valid event
        @(posedge core_clk) clk_en <= 1'b0;
        ev(7'd92);
        chk({err_word, error_state}, {16'h0436, 1'b0});
        @(posedge core_clk) clk_en <= 1'b1;
        $display("run-time test finished");
    endtask
    task automatic t_force;
        logic [6:0] f [4];
        f = '{7'd32, 7'd33, 7'd34, 7'd54};
        foreach (f[k]) begin
            ev(f[k]);
            chk({err_word.number, error_state}, {bcd(f[k]), 1'b1});
            to_program;
        end
        $display("forced error test finished");
    endtask
    task automatic t_remote(input logic [3:0] d, input logic [7:0] s);
        @(posedge core_clk) {send, status, delay} <= {1'b1, s, d};
        @(posedge core_clk) send <= 1'b0;
        cyc(d + 2);
        chk(err_word.number, bcd(s));
        chk({reply_send, reply_status_out}, {1'b1, s});
        $display("remote status test finished");
    endtask
    task automatic t_diag;
        @(posedge core_clk) {diag_rd, diag_addr} <= 4'b1010;
        @(posedge core_clk) diag_rd <= 1'b0;
        #1 chk(diag_valid, 1'b1);
        // index 2: one 90, ten each of 90 and 98 at run time, one 34
        chk(diag_data, 8'h16);
        $display("diagnostic test finished");
    endtask
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard, far beyond the expected 430 or so cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        errors++;
        give_verdict;
    end
    initial begin
        {rst_n, program_switch, prescan_start, header_candidate} = '0;
        {header_valid, end_of_memory, rung_done, prescan_done} = '0;
        {diag_rd, diag_addr, send, status, delay} = '0;
        {err_in, errors, n_compared} = '0;
        clk_en = 1'b1;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        cyc(3);
        chk({err_word, error_state}, '0);
        t_prescan(0, 7'd5);
        t_prescan(99, 7'd29);
        t_clean;
        t_runtime;
        t_force;
        t_remote(4'd0, 8'd85);
        t_remote(4'd9, 8'd89);
        t_diag;
        give_verdict;
    end
endmodule
bind err_code_word err_code_word_asserts u_chk (.*);
